// ==== verilog/lsram_pkg.sv ====
// Shared constants and carrier types for the local SRAM with base decode.
package lsram_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int LSRAM_MEM_BYTES = 4096;
  localparam int LSRAM_MEM_WORDS = 1024;
  localparam int LSRAM_INDEX_W   = 10;

  // ---------------------------------------------------------------------------
  // Configuration register: number, fields and write mask
  // ---------------------------------------------------------------------------
  localparam logic [11:0] LSRAM_CFG_REGNUM  = 12'hC04;
  localparam int          LSRAM_BASE_LSB    = 15;
  localparam int          LSRAM_HIT_LSB     = 12;
  localparam int          LSRAM_WP_BIT      = 8;
  localparam int          LSRAM_CI_BIT      = 5;
  localparam int          LSRAM_SC_BIT      = 4;
  localparam int          LSRAM_SD_BIT      = 3;
  localparam int          LSRAM_UC_BIT      = 2;
  localparam int          LSRAM_UD_BIT      = 1;
  localparam int          LSRAM_VALID_BIT   = 0;
  localparam logic [31:0] LSRAM_CFG_WMASK   = 32'hFFFF813F;
  localparam logic        LSRAM_VALID_RESET = 1'h0;

  // ---------------------------------------------------------------------------
  // Transfer size codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] LSRAM_SIZE_LONG = 2'h0;
  localparam logic [1:0] LSRAM_SIZE_BYTE = 2'h1;
  localparam logic [1:0] LSRAM_SIZE_WORD = 2'h2;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        debug;
    logic        cpu_space;
    logic        supervisor;
    logic        code;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lsram_req_t;

  typedef struct packed {
    logic ack;
    logic hit;
    logic access_error;
    logic no_alloc;
    logic pass_on;
  } lsram_rsp_t;

endpackage

// ==== verilog/lsram_array.sv ====
// Flip-flop storage array with byte enables and a registered read port.
`timescale 1ns/10ps
`default_nettype none

module lsram_array #(
  parameter int WORDS   = 1024,
  parameter int INDEX_W = 10
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               write_en,
  input  wire logic [3:0]         byte_en,
  input  wire logic [INDEX_W-1:0] index,
  input  wire logic [31:0]        wdata,
  output logic      [31:0]        rdata
);

  logic [31:0] store [WORDS];

  // Contents carry no reset; software must load the array before use.
  always_ff @(posedge clock) begin
    if (write_en) begin
      for (int b = 0; b < 4; b++) begin
        if (byte_en[b]) begin
          store[index][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

  // Read data is registered so the answer comes from a flip-flop.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= store[index];
    end
  end

endmodule

`default_nettype wire

// ==== verilog/lsram_top.sv ====
// Local SRAM with relocatable base, space masks and write protection.
//
// Functional notes
// - 4096 bytes as 1024 words of 32 bits
// - Every hit answers in one cycle, no waits
// - Byte, word and longword reads and writes
// - Base bits 31:15 place memory on 32K
// - Hit needs enable and address match base
// - Bit 0 enables decoding, clear means none
// - Reset clears only enable, others keep value
// - Write-lock blocks writes and raises access error
// - Five masks exclude space types from memory
// - Local hit data replaces discarded cache result
// - Local data never allocated into the cache
// - Serves processor and debug memory accesses
// - Register C04, privileged move, write-only from core
// - Debug unit reads and writes the register
// - Undefined bits ignore writes, read zero
`timescale 1ns/10ps
`default_nettype none

module lsram_top #(
  parameter int WORDS   = lsram_pkg::LSRAM_MEM_WORDS,
  parameter int INDEX_W = lsram_pkg::LSRAM_INDEX_W
) (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire lsram_pkg::lsram_req_t req,
  output lsram_pkg::lsram_rsp_t      rsp,
  output logic      [31:0]           rdata,
  input  wire logic                  cr_write,
  input  wire logic [11:0]           cr_num,
  input  wire logic [31:0]           cr_wdata,
  input  wire logic                  dbg_cfg_valid,
  input  wire logic                  dbg_cfg_write,
  input  wire logic [11:0]           dbg_cfg_num,
  input  wire logic [31:0]           dbg_cfg_wdata,
  output logic                       dbg_cfg_ack,
  output logic      [31:0]           dbg_cfg_rdata
);

  // ---------------------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------------------
  logic        cfg_valid;
  logic [31:1] cfg_rest;
  logic [31:0] cfg;
  logic        cfg_load;
  logic [31:0] next_cfg;
  logic        cpu_cfg_wr;
  logic        dbg_cfg_wr;

  assign cfg        = {cfg_rest, cfg_valid};
  assign cpu_cfg_wr = cr_write && (cr_num == lsram_pkg::LSRAM_CFG_REGNUM);
  assign dbg_cfg_wr = dbg_cfg_valid && dbg_cfg_write
                      && (dbg_cfg_num == lsram_pkg::LSRAM_CFG_REGNUM);
  assign cfg_load   = cpu_cfg_wr || dbg_cfg_wr;

  // Debug wins a same-cycle collision; reserved bits are dropped on write.
  always_comb begin
    if (dbg_cfg_wr) begin
      next_cfg = dbg_cfg_wdata & lsram_pkg::LSRAM_CFG_WMASK;
    end else begin
      next_cfg = cr_wdata & lsram_pkg::LSRAM_CFG_WMASK;
    end
  end

  // Only the enable flag is reset; the rest survives a hardware reset.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_valid <= lsram_pkg::LSRAM_VALID_RESET;
    end else if (cfg_load) begin
      cfg_valid <= next_cfg[lsram_pkg::LSRAM_VALID_BIT];
    end
  end

  // Deliberately no reset term here, so base, masks and lock persist.
  always_ff @(posedge clock) begin
    if (cfg_load) begin
      cfg_rest <= next_cfg[31:1];
    end
  end

  // The core has no read path; only the debug unit sees the register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dbg_cfg_ack   <= 1'h0;
      dbg_cfg_rdata <= 32'h00000000;
    end else begin
      dbg_cfg_ack <= dbg_cfg_valid;
      if (dbg_cfg_valid && !dbg_cfg_write) begin
        dbg_cfg_rdata <= (dbg_cfg_num == lsram_pkg::LSRAM_CFG_REGNUM)
                         ? (cfg & lsram_pkg::LSRAM_CFG_WMASK) : 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------------------
  logic       space_masked;
  logic       addr_match;
  logic       hit;
  logic       wp_block;
  logic       ram_we;
  logic [3:0] byte_en;

  // Pick the mask bit that governs this transfer type.
  always_comb begin
    if (req.cpu_space) begin
      space_masked = cfg[lsram_pkg::LSRAM_CI_BIT];
    end else if (req.supervisor) begin
      space_masked = req.code ? cfg[lsram_pkg::LSRAM_SC_BIT] : cfg[lsram_pkg::LSRAM_SD_BIT];
    end else begin
      space_masked = req.code ? cfg[lsram_pkg::LSRAM_UC_BIT] : cfg[lsram_pkg::LSRAM_UD_BIT];
    end
  end

  // The 4 KB window sits at the bottom of the 32K-aligned base.
  assign addr_match = req.addr[31:lsram_pkg::LSRAM_HIT_LSB]
                      == {cfg[31:lsram_pkg::LSRAM_BASE_LSB], 3'h0};
  assign hit        = req.valid && cfg_valid && addr_match && !space_masked;
  assign wp_block   = hit && req.write && cfg[lsram_pkg::LSRAM_WP_BIT];
  assign ram_we     = hit && req.write && !cfg[lsram_pkg::LSRAM_WP_BIT];

  // Big-endian lanes: byte 0 of a word is bits 31:24.
  always_comb begin
    unique case (req.size)
      lsram_pkg::LSRAM_SIZE_BYTE: byte_en = 4'h8 >> req.addr[1:0];
      lsram_pkg::LSRAM_SIZE_WORD: byte_en = req.addr[1] ? 4'h3 : 4'hC;
      default:                    byte_en = 4'hF;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  lsram_array #(
    .WORDS   (WORDS),
    .INDEX_W (INDEX_W)
  ) u_array (
    .clock    (clock),
    .reset_n  (reset_n),
    .write_en (ram_we),
    .byte_en  (byte_en),
    .index    (req.addr[INDEX_W+1:2]),
    .wdata    (req.wdata),
    .rdata    (rdata)
  );

  // ---------------------------------------------------------------------------
  // Response
  // ---------------------------------------------------------------------------
  // Every request is answered on the next edge; misses go on to the cache.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rsp <= '0;
    end else begin
      rsp.ack          <= req.valid;
      rsp.hit          <= hit;
      rsp.access_error <= wp_block;
      rsp.no_alloc     <= hit;
      rsp.pass_on      <= req.valid && !hit;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic [31:0] last_wr_data;
  logic        last_wr_long;

  // Remember a full-word write so the next-cycle readback can be checked.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_wr_data <= 32'h00000000;
      last_wr_long <= 1'h0;
    end else begin
      last_wr_data <= req.wdata;
      last_wr_long <= ram_we && (req.size == lsram_pkg::LSRAM_SIZE_LONG);
    end
  end

  AST_ONE_CYCLE: assert property (req.valid |=> rsp.ack)
    else $error("request not answered in one cycle");
  AST_HIT_DECODE: assert property (req.valid && cfg_valid && addr_match && !space_masked
                                   |=> rsp.hit && !rsp.pass_on)
    else $error("matching access did not hit");
  AST_DISABLED: assert property (req.valid && !cfg_valid |=> !rsp.hit && rsp.pass_on)
    else $error("hit while disabled");
  AST_MASKED: assert property (req.valid && space_masked |=> !rsp.hit && rsp.pass_on)
    else $error("masked space reached memory");
  AST_WP_ERROR: assert property (hit && req.write && cfg[lsram_pkg::LSRAM_WP_BIT]
                                 |=> rsp.access_error && rsp.hit)
    else $error("locked write gave no error");
  AST_WP_NOWRITE: assert property (req.valid && req.write && cfg[lsram_pkg::LSRAM_WP_BIT] |-> !ram_we)
    else $error("write reached locked memory");
  AST_NO_ALLOC: assert property (rsp.hit |-> rsp.no_alloc && !rsp.pass_on)
    else $error("local data allowed into cache");
  AST_DBG_ZERO: assert property (dbg_cfg_valid && !dbg_cfg_write
                                 |=> (dbg_cfg_rdata & ~lsram_pkg::LSRAM_CFG_WMASK) == 32'h00000000)
    else $error("reserved bits read nonzero");
  AST_CPU_LOAD: assert property (cpu_cfg_wr && !dbg_cfg_wr
                                 |=> cfg == ($past(cr_wdata) & lsram_pkg::LSRAM_CFG_WMASK))
    else $error("core register write not taken");
  AST_READBACK: assert property (last_wr_long && $past(req.addr) == req.addr && req.valid && !req.write
                                 |=> rdata == $past(last_wr_data))
    else $error("readback mismatch");

  COV_READ_HIT: cover property (req.valid && !req.write && hit ##1 rsp.hit);
  COV_WRITE_HIT: cover property (ram_we ##1 rsp.hit);
  COV_WP_ERROR: cover property (wp_block ##1 rsp.access_error);
  COV_DEBUG_HIT: cover property (req.debug && hit);

endmodule

`default_nettype wire

// ==== testbench/lsram_cpu.sv ====
// Stand-in for the core's local bus and the debug unit; drives on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module lsram_cpu (
  input  wire logic                  clock,
  input  wire lsram_pkg::lsram_rsp_t rsp,
  input  wire logic                  dbg_cfg_ack,
  input  wire logic [31:0]           dbg_cfg_rdata,
  output lsram_pkg::lsram_req_t      req,
  output logic                       cr_write,
  output logic [11:0]                cr_num,
  output logic [31:0]                cr_wdata,
  output logic                       dbg_cfg_valid,
  output logic                       dbg_cfg_write,
  output logic [11:0]                dbg_cfg_num,
  output logic [31:0]                dbg_cfg_wdata
);
  // Everything starts idle so nothing can be taken before reset is released.
  initial begin
    req = '0;
    {cr_write, cr_num, cr_wdata} = '0;
    {dbg_cfg_valid, dbg_cfg_write, dbg_cfg_num, dbg_cfg_wdata} = '0;
  end

  // One access for one cycle; t is 1 user data, 2 user code, 3 sup data, 4 sup code, 5 CPU space.
  task automatic mem(input logic w, d, input int t, input logic [1:0] sz, input logic [31:0] a, wd,
                     output lsram_pkg::lsram_rsp_t r);
    req <= {1'b1, w, d, (t == 5), (t == 4 || t == 3), (t == 4 || t == 2), sz, a, wd};
    @(negedge clock);
    r = rsp;
  endtask

  // Control-register move; the core has no read path, so nothing comes back.
  task automatic crw(input logic [11:0] n, input logic [31:0] v);
    req.valid <= 1'b0;
    req.addr <= ~req.addr;
    cr_write <= 1'b1;
    cr_num <= n;
    cr_wdata <= v;
    @(negedge clock);
    cr_write <= 1'b0;
    cr_wdata <= ~v;
    @(negedge clock);
  endtask

  // Debug access to the configuration register; stale data is inverted on release.
  task automatic dbg(input logic w, input logic [31:0] v, output logic [31:0] r, output logic k);
    req.valid <= 1'b0;
    req.addr <= ~req.addr;
    dbg_cfg_valid <= 1'b1;
    dbg_cfg_write <= w;
    dbg_cfg_num <= 12'hC04;
    dbg_cfg_wdata <= v;
    @(negedge clock);
    k = dbg_cfg_ack;
    r = dbg_cfg_rdata;
    dbg_cfg_valid <= 1'b0;
    dbg_cfg_wdata <= ~v;
    @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ==== testbench/lsram_top_bench.sv ====
// Self-checking bench for the local SRAM with base decode.
`timescale 1ns/10ps
`default_nettype none
module lsram_top_bench;
  localparam logic [31:0] B = 32'h20000000;
  logic                  clock = 1'b0;
  logic                  reset_n;
  logic                  wp;
  logic                  k;
  logic                  cr_write, dbg_cfg_valid, dbg_cfg_write, dbg_cfg_ack;
  logic [11:0]           cr_num, dbg_cfg_num;
  logic [31:0]           rdata, cr_wdata, dbg_cfg_wdata, dbg_cfg_rdata, v;
  lsram_pkg::lsram_req_t req;
  lsram_pkg::lsram_rsp_t rsp;
  int                    err_count = 0;
  int                    num_checks = 0;

  lsram_top lsram_top_i (.clock, .reset_n, .req, .rsp, .rdata, .cr_write, .cr_num, .cr_wdata,
    .dbg_cfg_valid, .dbg_cfg_write, .dbg_cfg_num, .dbg_cfg_wdata, .dbg_cfg_ack, .dbg_cfg_rdata);
  lsram_cpu lsram_cpu_i (.clock, .rsp, .dbg_cfg_ack, .dbg_cfg_rdata, .req, .cr_write, .cr_num,
    .cr_wdata, .dbg_cfg_valid, .dbg_cfg_write, .dbg_cfg_num, .dbg_cfg_wdata);

  // 20 MHz core clock.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Counts every comparison and reports a mismatch on its own line.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One access; a hit must never be cached, a miss must go on to the cache path.
  task automatic acc(input logic w, d, input int t, input logic [1:0] sz, input logic [31:0] a, wd,
                     input logic h);
    lsram_pkg::lsram_rsp_t r;
    lsram_cpu_i.mem(w, d, t, sz, a, wd, r);
    chk("ack", 32'h1, 32'(r.ack));
    chk("hit", 32'(h), 32'(r.hit));
    chk("no_alloc", 32'(h), 32'(r.no_alloc));
    chk("pass_on", 32'(!h), 32'(r.pass_on));
    chk("access_error", 32'(w & h & wp), 32'(r.access_error));
  endtask

  // Longword read that must hit and return e in the very next cycle.
  task automatic rd(input logic d, input logic [31:0] a, e);
    acc(1'b0, d, 1, 2'h0, a, 32'h0, 1'b1);
    chk("rdata", e, rdata);
  endtask

  // Debug read of the configuration register.
  task automatic cfg(input logic [31:0] e);
    lsram_cpu_i.dbg(1'b0, 32'h0, v, k);
    chk("dbg_ack", 32'h1, 32'(k));
    chk("cfg", e, v);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence; accesses chain back to back, register moves release the bus first.
  initial begin
    wp = 1'b0;
    reset_n = 1'b0;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    acc(1'b0, 1'b0, 1, 2'h0, B, 32'h0, 1'b0);
    lsram_cpu_i.crw(12'hC04, 32'h20000001);
    lsram_cpu_i.crw(12'hC05, 32'h00000000);
    cfg(32'h20000001);
    lsram_cpu_i.dbg(1'b1, 32'hFFFFFFFF, v, k);
    cfg(32'hFFFF813F);
    lsram_cpu_i.dbg(1'b1, 32'h20000001, v, k);
    acc(1'b1, 1'b0, 1, 2'h0, B, 32'h11223344, 1'b1);
    acc(1'b1, 1'b0, 1, 2'h0, B + 32'hFFC, 32'hA5A5A5A5, 1'b1);
    acc(1'b1, 1'b0, 1, 2'h1, B + 32'h1, 32'h00EE0000, 1'b1);
    acc(1'b1, 1'b0, 1, 2'h2, B + 32'h2, 32'h0000BEEF, 1'b1);
    rd(1'b0, B, 32'h11EEBEEF);
    rd(1'b1, B + 32'hFFC, 32'hA5A5A5A5);
    acc(1'b0, 1'b0, 1, 2'h0, B + 32'h1000, 32'h0, 1'b0);
    acc(1'b0, 1'b0, 1, 2'h0, B + 32'h8000, 32'h0, 1'b0);
    for (int i = 1; i <= 5; i++) begin
      lsram_cpu_i.crw(12'hC04, 32'h20000001 | (32'h1 << i));
      for (int j = 1; j <= 5; j++) begin
        acc(1'b0, 1'b0, j, 2'h0, B, 32'h0, (i != j));
      end
    end
    lsram_cpu_i.crw(12'hC04, 32'h20000101);
    wp = 1'b1;
    acc(1'b1, 1'b0, 1, 2'h0, B, 32'hDEADBEEF, 1'b1);
    rd(1'b0, B, 32'h11EEBEEF);
    cfg(32'h20000101);
    reset_n = 1'b0;
    @(negedge clock);
    reset_n = 1'b1;
    cfg(32'h20000100);
    acc(1'b0, 1'b0, 1, 2'h0, B, 32'h0, 1'b0);
    lsram_cpu_i.crw(12'hC04, 32'hFFFF8001);
    wp = 1'b0;
    acc(1'b1, 1'b0, 1, 2'h0, 32'hFFFF8010, 32'h0BADF00D, 1'b1);
    rd(1'b0, 32'hFFFF8010, 32'h0BADF00D);
    acc(1'b0, 1'b0, 1, 2'h0, B, 32'h0, 1'b0);
    final_report();
  end

  // The sequence needs about 85 cycles; 3000 cycles is over thirty times that and can only be a hang.
  initial begin
    #(50 * 3000);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
